// file: logic/pnds_pkg.sv
package pnds_pkg;
    // ==========================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_TRIG_SEL = 16'hFFA1;
    localparam logic [15:0] IDX_EN_HIGH = 16'hFFA2;
    localparam logic [15:0] IDX_EN_LOW = 16'hFFA3;
    localparam logic [15:0] IDX_ND_HI_PAIR_B = 16'hFFA4;
    localparam logic [15:0] IDX_ND_HI_PAIR_A = 16'hFFA5;
    localparam logic [15:0] IDX_ND_LO_PAIR_B = 16'hFFA6;
    localparam logic [15:0] IDX_ND_LO_PAIR_A = 16'hFFA7;
    localparam logic [15:0] IDX_PORT_A = 16'hFFD3;
    localparam logic [15:0] IDX_PORT_B = 16'hFFD6;
    localparam int IDX_LSB = 2;
    localparam int MIN_ADDR_W = 18;

    // ==========================================
    // Widths and field layout
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int GROUPS = 4;
    localparam int SEL_W = 2;
    localparam int NIB_HI = 4;

    // ==========================================
    // Reset and reserved values
    localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RSV_BYTE = 8'hFF;
    localparam logic [3:0] RSV_NIB = 4'hF;
    localparam logic [31:0] RD_ZERO = 32'h00000000;
    localparam logic [1:0] ALIGNED = 2'h0;
endpackage : pnds_pkg

// file: logic/pnds_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module pnds_trigger
    import pnds_pkg::*;
(
    // Trigger select and timer events
    input wire logic [BYTE_W-1:0] group_trigger_select,
    input wire logic [GROUPS-1:0] cmp_match,
    // Per-group fire and pair decode mode
    output logic [GROUPS-1:0] group_fire,
    output logic shared_pair_a,
    output logic shared_pair_b
);
    // ==========================================
    // Channel mux per group
    for (genvar g = 0; g < GROUPS; g++) begin : g_sel
        logic [SEL_W-1:0] group_channel_select;
        assign group_channel_select = group_trigger_select[g*SEL_W +: SEL_W];
        assign group_fire[g] = cmp_match[group_channel_select];
    end

    // ==========================================
    // Pair shares one address when both groups pick the same channel
    assign shared_pair_a = group_trigger_select[0 +: SEL_W]
        == group_trigger_select[SEL_W +: SEL_W];
    assign shared_pair_b = group_trigger_select[2*SEL_W +: SEL_W]
        == group_trigger_select[3*SEL_W +: SEL_W];
endmodule : pnds_trigger
`default_nettype wire

// file: logic/pnds_port_latch.sv
`timescale 1ns/1ps
`default_nettype none
module pnds_port_latch
    import pnds_pkg::*;
#(
    parameter int W = 8,
    parameter int GROUP_W = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clear,
    // Software write
    input wire logic wr,
    input wire logic [W-1:0] wdata,
    // Pattern copy
    input wire logic [W-1:0] copy_enable,
    input wire logic [W-1:0] staged,
    input wire logic [W/GROUP_W-1:0] fire,
    // Latch value driving the pins
    output logic [W-1:0] latch
);
    if (GROUP_W < 1 || W % GROUP_W != 0) begin : g_bad_width
        $error("W must be a multiple of GROUP_W");
    end

    typedef struct packed {
        logic [W-1:0] value;
    } pnds_latch_s;

    pnds_latch_s st;
    pnds_latch_s next_st;
    logic [W-1:0] next_bits;

    // ==========================================
    // Per-bit copy and write mask
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            if (fire[i/GROUP_W] && copy_enable[i]) begin
                next_bits[i] = staged[i];
            end else if (wr && !copy_enable[i]) begin
                next_bits[i] = wdata[i];
            end else begin
                next_bits[i] = st.value[i];
            end
        end
    end

    always_comb begin
        next_st.value = clear ? '0 : next_bits;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign latch = st.value;
endmodule : pnds_port_latch
`default_nettype wire

// file: logic/pnds_top.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Hold eight staged bits for low pins; copy a group's bits to port A on its trigger.
// - Low staged byte clears on reset and hardware standby; kept in software standby.
// - Pair A shared trigger: whole low staged byte at first address, nibbles per group.
// - Pair A shared trigger: companion address reads all ones, ignores writes.
// - Pair A split: group 1 nibble high at first address, group 0 low at second.
// - Pair A split: unused nibbles of both addresses read ones, ignore writes.
// - Hold eight staged bits for high pins; copy a group's bits to port B on its trigger.
// - High staged byte clears on reset and hardware standby; kept in software standby.
// - Pair B shared trigger: whole high staged byte at first address, nibbles per group.
// - Pair B shared trigger: companion address reads all ones, ignores writes.
// - Pair B split: group 3 nibble high at first address, group 2 low at second.
// - Pair B split: unused nibbles of both addresses read ones, ignore writes.
// - Low-pin enable one lets the copy happen; zero blocks it, output holds.
// - High-pin enable one lets the copy happen; zero blocks it, output holds.
// - Low-pin enable register clears on reset and hardware standby only.
// - High-pin enable register clears on reset and hardware standby only.
// - Each group picks timer channel 0 to 3 by two bits; all reset to channel 3.
// - Port latch bits with copy enabled ignore software writes.
module pnds_top
    import pnds_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Hardware standby pin, active high
    input wire logic hw_standby,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Timer compare-match strobes, one per channel
    input wire logic [GROUPS-1:0] cmp_match,
    // Pattern pin latches
    output logic [BYTE_W-1:0] port_a_latch,
    output logic [BYTE_W-1:0] port_b_latch
);
    if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W too narrow for the register indices");
    end

    typedef struct packed {
        logic [BYTE_W-1:0] trig_sel;
        logic [BYTE_W-1:0] en_low;
        logic [BYTE_W-1:0] en_high;
        logic [BYTE_W-1:0] staged_low;
        logic [BYTE_W-1:0] staged_high;
        logic [31:0] rdata;
        logic slverr;
        logic stby_meta;
        logic stby;
    } pnds_main_s;

    pnds_main_s st;
    pnds_main_s next_st;

    logic [GROUPS-1:0] group_fire;
    logic shared_a;
    logic shared_b;
    logic [15:0] idx;
    logic setup;
    logic wr_acc;
    logic rd_hit;
    logic [BYTE_W-1:0] rd_val;
    logic [BYTE_W-1:0] wd;
    logic wr_port_a;
    logic wr_port_b;

    // ==========================================
    // Trigger selection
    pnds_trigger u_trigger (
        .group_trigger_select(st.trig_sel),
        .cmp_match(cmp_match),
        .group_fire(group_fire),
        .shared_pair_a(shared_a),
        .shared_pair_b(shared_b)
    );

    // ==========================================
    // Bus decode
    assign idx = paddr[IDX_LSB +: 16];
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pstrb[0] && !st.slverr;
    assign wd = pwdata[BYTE_W-1:0];
    assign wr_port_a = wr_acc && idx == IDX_PORT_A;
    assign wr_port_b = wr_acc && idx == IDX_PORT_B;
    // No wait states: read data is captured during setup
    assign pready = psel && penable;
    assign prdata = st.rdata;
    assign pslverr = st.slverr;

    // ==========================================
    // Read mux
    always_comb begin
        rd_hit = paddr[IDX_LSB-1:0] == ALIGNED;
        rd_val = RST_BYTE;
        unique case (idx)
            IDX_TRIG_SEL: rd_val = st.trig_sel;
            IDX_EN_HIGH: rd_val = st.en_high;
            IDX_EN_LOW: rd_val = st.en_low;
            IDX_PORT_A: rd_val = port_a_latch;
            IDX_PORT_B: rd_val = port_b_latch;
            IDX_ND_HI_PAIR_B: begin
                rd_val = shared_b ? st.staged_high
                    : {st.staged_high[NIB_HI +: NIB_W], RSV_NIB};
            end
            IDX_ND_HI_PAIR_A: begin
                rd_val = shared_a ? st.staged_low
                    : {st.staged_low[NIB_HI +: NIB_W], RSV_NIB};
            end
            IDX_ND_LO_PAIR_B: begin
                rd_val = shared_b ? RSV_BYTE
                    : {RSV_NIB, st.staged_high[0 +: NIB_W]};
            end
            IDX_ND_LO_PAIR_A: begin
                rd_val = shared_a ? RSV_BYTE
                    : {RSV_NIB, st.staged_low[0 +: NIB_W]};
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // ==========================================
    // Register update
    always_comb begin
        next_st = st;
        next_st.stby_meta = hw_standby;
        next_st.stby = st.stby_meta;
        if (setup) begin
            next_st.rdata = rd_hit ? {{(32-BYTE_W){1'b0}}, rd_val} : RD_ZERO;
            next_st.slverr = !rd_hit;
        end
        if (wr_acc) begin
            unique case (idx)
                IDX_TRIG_SEL: next_st.trig_sel = wd;
                IDX_EN_HIGH: next_st.en_high = wd;
                IDX_EN_LOW: next_st.en_low = wd;
                IDX_ND_HI_PAIR_B: begin
                    if (shared_b) begin
                        next_st.staged_high = wd;
                    end else begin
                        next_st.staged_high[NIB_HI +: NIB_W] = wd[NIB_HI +: NIB_W];
                    end
                end
                IDX_ND_HI_PAIR_A: begin
                    if (shared_a) begin
                        next_st.staged_low = wd;
                    end else begin
                        next_st.staged_low[NIB_HI +: NIB_W] = wd[NIB_HI +: NIB_W];
                    end
                end
                IDX_ND_LO_PAIR_B: begin
                    if (!shared_b) begin
                        next_st.staged_high[0 +: NIB_W] = wd[0 +: NIB_W];
                    end
                end
                IDX_ND_LO_PAIR_A: begin
                    if (!shared_a) begin
                        next_st.staged_low[0 +: NIB_W] = wd[0 +: NIB_W];
                    end
                end
                default: begin
                end
            endcase
        end
        // Standby wins over a same-cycle write; software standby has no effect
        if (st.stby) begin
            next_st.trig_sel = RST_TRIG_SEL;
            next_st.en_low = RST_BYTE;
            next_st.en_high = RST_BYTE;
            next_st.staged_low = RST_BYTE;
            next_st.staged_high = RST_BYTE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{trig_sel: RST_TRIG_SEL, en_low: RST_BYTE, en_high: RST_BYTE,
                    staged_low: RST_BYTE, staged_high: RST_BYTE, rdata: RD_ZERO,
                    slverr: 1'b0, stby_meta: 1'b0, stby: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Port latches
    pnds_port_latch #(.W(BYTE_W), .GROUP_W(NIB_W)) u_port_a (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(st.stby),
        .wr(wr_port_a),
        .wdata(wd),
        .copy_enable(st.en_low),
        .staged(st.staged_low),
        .fire(group_fire[1:0]),
        .latch(port_a_latch)
    );

    pnds_port_latch #(.W(BYTE_W), .GROUP_W(NIB_W)) u_port_b (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(st.stby),
        .wr(wr_port_b),
        .wdata(wd),
        .copy_enable(st.en_high),
        .staged(st.staged_high),
        .fire(group_fire[3:2]),
        .latch(port_b_latch)
    );

    // ==========================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || st.stby);

    property p_copy_low;
        group_fire[0] && st.en_low[0] |=> port_a_latch[0] == $past(st.staged_low[0]);
    endproperty
    a_copy_low: assert property (p_copy_low) else $error("port A bit 0 not copied");

    property p_copy_high;
        group_fire[3] && st.en_high[7] |=> port_b_latch[7] == $past(st.staged_high[7]);
    endproperty
    a_copy_high: assert property (p_copy_high) else $error("port B bit 7 not copied");

    property p_block_low;
        !st.en_low[2] && !wr_port_a |=> $stable(port_a_latch[2]);
    endproperty
    a_block_low: assert property (p_block_low) else $error("disabled bit changed");

    property p_block_high;
        !st.en_high[4] && !wr_port_b |=> $stable(port_b_latch[4]);
    endproperty
    a_block_high: assert property (p_block_high) else $error("disabled bit changed");

    property p_ro_latch;
        wr_port_a && st.en_low[5] && !group_fire[1] |=> $stable(port_a_latch[5]);
    endproperty
    a_ro_latch: assert property (p_ro_latch) else $error("enabled latch bit written");

    property p_shared_read;
        setup && !pwrite && shared_a && idx == IDX_ND_LO_PAIR_A && rd_hit
            |=> prdata == 32'h000000FF ##0 pready || !psel;
    endproperty
    a_shared_read: assert property (p_shared_read) else $error("reserved byte not ones");

    property p_split_read;
        setup && !pwrite && !shared_b && idx == IDX_ND_HI_PAIR_B && rd_hit
            |=> prdata[3:0] == 4'hF && prdata[7:4] == $past(st.staged_high[7:4]);
    endproperty
    a_split_read: assert property (p_split_read) else $error("split read wrong");

    property p_shared_write;
        wr_acc && idx == IDX_ND_HI_PAIR_B && shared_b |=> st.staged_high == $past(wd);
    endproperty
    a_shared_write: assert property (p_shared_write) else $error("shared write lost");

    property p_companion_ignored;
        wr_acc && idx == IDX_ND_LO_PAIR_A && shared_a |=> $stable(st.staged_low);
    endproperty
    a_companion_ignored: assert property (p_companion_ignored) else $error("reserved write");

    property p_split_low_nibble;
        wr_acc && idx == IDX_ND_LO_PAIR_A && !shared_a
            |=> st.staged_low[3:0] == $past(wd[3:0]) && $stable(st.staged_low[7:4]);
    endproperty
    a_split_low_nibble: assert property (p_split_low_nibble) else $error("split write");

    property p_mode;
        shared_b == (st.trig_sel[5:4] == st.trig_sel[7:6]);
    endproperty
    a_mode: assert property (p_mode) else $error("pair B decode mode wrong");

    property p_select;
        group_fire[2] == cmp_match[st.trig_sel[5:4]];
    endproperty
    a_select: assert property (p_select) else $error("group 2 trigger mux wrong");

    property p_stby_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        st.stby |=> st.staged_low == 8'h00 && st.en_high == 8'h00 && st.trig_sel == 8'hFF;
    endproperty
    a_stby_clear: assert property (p_stby_clear) else $error("standby did not clear");

    property p_rd_a_shared;
        setup && !pwrite && shared_a && idx == IDX_ND_HI_PAIR_A && rd_hit
            |=> prdata[BYTE_W-1:0] == $past(st.staged_low);
    endproperty
    a_rd_a_shared: assert property (p_rd_a_shared) else $error("shared byte read wrong");

    property p_rd_a_split;
        setup && !pwrite && !shared_a && idx == IDX_ND_LO_PAIR_A && rd_hit
            |=> prdata[7:4] == RSV_NIB && prdata[3:0] == $past(st.staged_low[3:0]);
    endproperty
    a_rd_a_split: assert property (p_rd_a_split) else $error("split read wrong");

    property p_rd_b_companion;
        setup && !pwrite && shared_b && idx == IDX_ND_LO_PAIR_B && rd_hit
            |=> prdata[BYTE_W-1:0] == RSV_BYTE;
    endproperty
    a_rd_b_companion: assert property (p_rd_b_companion) else $error("reserved byte");

    property p_rd_b_split;
        setup && !pwrite && !shared_b && idx == IDX_ND_LO_PAIR_B && rd_hit
            |=> prdata[7:4] == RSV_NIB && prdata[3:0] == $past(st.staged_high[3:0]);
    endproperty
    a_rd_b_split: assert property (p_rd_b_split) else $error("split read wrong");

    property p_wr_a_shared;
        wr_acc && idx == IDX_ND_HI_PAIR_A && shared_a |=> st.staged_low == $past(wd);
    endproperty
    a_wr_a_shared: assert property (p_wr_a_shared) else $error("shared write lost");

    property p_wr_a_split_hi;
        wr_acc && idx == IDX_ND_HI_PAIR_A && !shared_a
            |=> st.staged_low[7:4] == $past(wd[7:4]) && $stable(st.staged_low[3:0]);
    endproperty
    a_wr_a_split_hi: assert property (p_wr_a_split_hi) else $error("split write");

    property p_wr_b_companion;
        wr_acc && idx == IDX_ND_LO_PAIR_B && shared_b |=> $stable(st.staged_high);
    endproperty
    a_wr_b_companion: assert property (p_wr_b_companion) else $error("reserved write");

    property p_wr_b_split_hi;
        wr_acc && idx == IDX_ND_HI_PAIR_B && !shared_b
            |=> st.staged_high[7:4] == $past(wd[7:4]) && $stable(st.staged_high[3:0]);
    endproperty
    a_wr_b_split_hi: assert property (p_wr_b_split_hi) else $error("split write");

    property p_wr_b_split_lo;
        wr_acc && idx == IDX_ND_LO_PAIR_B && !shared_b
            |=> st.staged_high[3:0] == $past(wd[3:0]) && $stable(st.staged_high[7:4]);
    endproperty
    a_wr_b_split_lo: assert property (p_wr_b_split_lo) else $error("split write");

    property p_stby_high;
        @(posedge ref_clk) disable iff (!rst_n)
        st.stby |=> st.staged_high == RST_BYTE && port_b_latch == RST_BYTE;
    endproperty
    a_stby_high: assert property (p_stby_high) else $error("standby did not clear");

    property p_stby_en_low;
        @(posedge ref_clk) disable iff (!rst_n)
        st.stby |=> st.en_low == RST_BYTE && port_a_latch == RST_BYTE;
    endproperty
    a_stby_en_low: assert property (p_stby_en_low) else $error("standby did not clear");
endmodule : pnds_top
`default_nettype wire

// file: test/pnds_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Timer compare-match source
module pnds_timer_model
    import pnds_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bench request
    input wire logic go,
    input wire logic [GROUPS-1:0] mask,
    // Strobes to the block
    output logic [GROUPS-1:0] cmp_match
);
    // One-cycle strobe per request cycle, as the timer gives
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_match <= '0;
        end else begin
            cmp_match <= go ? mask : '0;
        end
    end
endmodule : pnds_timer_model
`default_nettype wire

// file: test/test_pulse_next_data_staging.sv
`timescale 1ns/1ps
`default_nettype none
module test_pulse_next_data_staging
    import pnds_pkg::*;
();
    // ==========================================
    // Signals and instances
    logic ref_clk, rst_n, hw_standby, psel, penable, pwrite, go, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, mask, cmp_match;
    logic [7:0] port_a_latch, port_b_latch;
    int n_fail, n_tests, seed;
    bit [7:0] m_sel, m_en_a, m_en_b, m_nd_a, m_nd_b, m_pa, m_pb;
    bit [15:0] idx_tab [0:9] = '{IDX_TRIG_SEL, IDX_EN_HIGH, IDX_EN_LOW, IDX_ND_HI_PAIR_B,
        IDX_ND_HI_PAIR_A, IDX_ND_LO_PAIR_B, IDX_ND_LO_PAIR_A, IDX_PORT_A, IDX_PORT_B, 16'hFFB0};

    pnds_timer_model tmr (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .mask(mask),
        .cmp_match(cmp_match));
    pnds_top #(.ADDR_W(18)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .hw_standby(hw_standby),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cmp_match(cmp_match), .port_a_latch(port_a_latch), .port_b_latch(port_b_latch));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ==========================================
    // Reference model
    function automatic bit shr(input int p);
        return m_sel[4*p+:2] == m_sel[4*p+2+:2];
    endfunction : shr

    function automatic bit [31:0] m_read(input bit [15:0] i);
        case (i)
            IDX_TRIG_SEL: return {24'h0, m_sel};
            IDX_EN_HIGH: return {24'h0, m_en_b};
            IDX_EN_LOW: return {24'h0, m_en_a};
            IDX_ND_HI_PAIR_B: return {24'h0, shr(1) ? m_nd_b : {m_nd_b[7:4], 4'hF}};
            IDX_ND_HI_PAIR_A: return {24'h0, shr(0) ? m_nd_a : {m_nd_a[7:4], 4'hF}};
            IDX_ND_LO_PAIR_B: return {24'h0, shr(1) ? 8'hFF : {4'hF, m_nd_b[3:0]}};
            IDX_ND_LO_PAIR_A: return {24'h0, shr(0) ? 8'hFF : {4'hF, m_nd_a[3:0]}};
            IDX_PORT_A: return {24'h0, m_pa};
            IDX_PORT_B: return {24'h0, m_pb};
            default: return 32'h0;
        endcase
    endfunction : m_read

    function automatic void m_write(input bit [15:0] i, input bit [7:0] d);
        case (i)
            IDX_TRIG_SEL: m_sel = d;
            IDX_EN_HIGH: m_en_b = d;
            IDX_EN_LOW: m_en_a = d;
            IDX_ND_HI_PAIR_B: m_nd_b = shr(1) ? d : {d[7:4], m_nd_b[3:0]};
            IDX_ND_HI_PAIR_A: m_nd_a = shr(0) ? d : {d[7:4], m_nd_a[3:0]};
            IDX_ND_LO_PAIR_B: if (!shr(1)) m_nd_b[3:0] = d[3:0];
            IDX_ND_LO_PAIR_A: if (!shr(0)) m_nd_a[3:0] = d[3:0];
            IDX_PORT_A: m_pa = (m_pa & m_en_a) | (d & ~m_en_a);
            IDX_PORT_B: m_pb = (m_pb & m_en_b) | (d & ~m_en_b);
            default: ;
        endcase
    endfunction : m_write

    function automatic void m_fire(input bit [3:0] c);
        bit [7:0] ma;
        bit [7:0] mb;
        ma = '0;
        mb = '0;
        for (int g = 0; g < 4; g++) begin
            if (c[m_sel[2*g+:2]] && g < 2) ma[4*g+:4] = 4'hF;
            if (c[m_sel[2*g+:2]] && g >= 2) mb[4*(g-2)+:4] = 4'hF;
        end
        ma &= m_en_a;
        mb &= m_en_b;
        m_pa = (m_pa & ~ma) | (m_nd_a & ma);
        m_pb = (m_pb & ~mb) | (m_nd_b & mb);
    endfunction : m_fire

    // ==========================================
    // Compare tasks
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_err(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t error flag %b expected %b", $time, got, exp);
        end
    endtask : chk_err

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t pins %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    // ==========================================
    // Bus and event tasks
    task automatic apb(input bit wr, input bit [15:0] i, input bit [7:0] d, input bit [1:0] lo,
        input bit s0, output logic [31:0] rd, output logic er);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {i, lo};
        pwdata <= {24'h0, d};
        pstrb <= {3'h0, s0};
        @(posedge ref_clk);
        penable <= 1'b1;
        // Waits as long as the slave stretches; the watchdog ends a hang
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic acc(input bit wr, input bit [15:0] i, input bit [7:0] d, input bit [1:0] lo,
        input bit s0);
        logic [31:0] rd;
        logic er;
        bit bad;
        bad = lo != 2'h0 || i == 16'hFFB0;
        apb(wr, i, d, lo, s0, rd, er);
        if (!wr) chk_rd(rd, bad ? 32'h0 : m_read(i));
        chk_err(er, bad);
        if (wr && s0 && !bad) m_write(i, d);
        @(negedge ref_clk);
        chk_pin({port_b_latch, port_a_latch}, {m_pb, m_pa});
    endtask : acc

    task automatic fire(input bit [3:0] c);
        @(posedge ref_clk);
        go <= 1'b1;
        mask <= c;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        m_fire(c);
        @(negedge ref_clk);
        // Latch taken as pin level: the block has no pin direction control
        chk_pin({port_b_latch, port_a_latch}, {m_pb, m_pa});
    endtask : fire

    task automatic standby();
        @(posedge ref_clk);
        hw_standby <= 1'b1;
        repeat (6) @(posedge ref_clk);
        hw_standby <= 1'b0;
        repeat (5) @(posedge ref_clk);
        {m_sel, m_en_a, m_en_b, m_nd_a, m_nd_b, m_pa, m_pb} = {8'hFF, 48'h0};
        @(negedge ref_clk);
        chk_pin({port_b_latch, port_a_latch}, 16'h0000);
    endtask : standby

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] r;
        seed = 21714;
        {hw_standby, psel, penable, pwrite, go, mask, paddr, pwdata, pstrb} = '0;
        {m_sel, m_en_a, m_en_b, m_nd_a, m_nd_b, m_pa, m_pb} = {8'hFF, 48'h0};
        n_fail = 0;
        n_tests = 0;
        rst_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 10; k++) acc(1'b0, idx_tab[k], 8'h00, 2'h0, 1'b1);
        repeat (600) begin
            r = $random(seed);
            if (r[3:0] < 6) begin
                acc(1'b1, idx_tab[r[15:8] % 10], r[23:16], 2'h0, r[24] | r[25]);
            end else if (r[3:0] < 11) begin
                acc(1'b0, idx_tab[r[15:8] % 10], 8'h00, 2'h0, 1'b1);
            end else if (r[3:0] < 14) begin
                fire(r[19:16]);
            end else if (r[3:0] == 14) begin
                acc(r[4], idx_tab[r[15:8] % 9], r[23:16], {r[5], 1'b1}, 1'b1);
            end else if (r[7:4] == 0) begin
                standby();
                for (int k = 0; k < 9; k++) acc(1'b0, idx_tab[k], 8'h00, 2'h0, 1'b1);
            end
        end
        // Standby once for sure, whatever the random draw gave
        standby();
        for (int k = 0; k < 9; k++) acc(1'b0, idx_tab[k], 8'h00, 2'h0, 1'b1);
        results();
    end

    // Hang guard, far beyond the few thousand cycles needed
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        $display("FAIL %0t watchdog expired", $time);
        results();
    end
endmodule : test_pulse_next_data_staging
`default_nettype wire
